// file: rtl/tsf_transmit_status_flags.sv
// transmit status register with sticky event flags and interrupt logic
`timescale 1ns/10ps
`include "tsf_defines.svh"

// How it works
// - hardware set beats a same-cycle clear; flag stays set, interrupt stays asserted
// - bit 8 reads OR of starved, early sync, clock fault, overwrite
// - bit 7 sets when more serializers written per slot than transmitters
// - interrupt asserts while any flag and its enable are both one
// - flags reset to zero; write one clears, write zero leaves alone
// - bit 6 sets on a new frame sync pulse
// - bit 5 sets when holding buffer moves into shift register
// - bit 5 also sets when serializers leave reset
// - each setting of bit 5 raises a dma request
// - bit 4 sets with bit 5 when slot is last of frame
// - bit 3 mirrors slot counter lsb, read only
// - bits 31 to 9 read zero and ignore writes
// - early sync flag sets on frame sync earlier than expected
// - starved flag sets on move with no new buffer data
// - clock fault flag sets when clock checker reports error
// - enable bits: 7,5,4,3,2,1,0 as frame, data, last, overwrite, clk, sync, under
module tsf_transmit_status_flags (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic port_overwrite,
    input wire logic frame_start,
    input wire logic buffer_moved,
    input wire logic serializer_release,
    input wire logic final_slot,
    input wire logic clock_fault,
    input wire logic early_sync,
    input wire logic starved,
    input wire logic tx_slot_counter_lsb,
    output logic tx_interrupt_request,
    output logic tx_dma_request
);

    // ************************************************************
    // bus decode
    // ************************************************************
    tsf_pkg::tsf_bus_req_t req;
    tsf_pkg::tsf_events_t ev;
    tsf_pkg::tsf_flags_t flags;
    tsf_pkg::tsf_flags_t set_vec;
    tsf_pkg::tsf_flags_t clr_vec;
    logic status_wr;
    logic enables_wr;
    logic [7:0] enables;
    logic [7:0] next_enables;
    logic [31:0] rdata_mux;
    logic [31:0] next_rdata;
    logic buffer_set;
    logic next_dma;
    logic error_sum;

    function automatic logic tsf_hit(input logic [7:0] a, input logic [7:0] o);
        tsf_hit = (a == o);
    endfunction

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
    assign ev = '{port_overwrite: port_overwrite, frame_start: frame_start,
                  buffer_moved: buffer_moved,
                  serializer_release: serializer_release,
                  final_slot: final_slot, clock_fault: clock_fault,
                  early_sync: early_sync, starved: starved};
    assign status_wr = req.wr && tsf_hit(req.addr, `TSF_STATUS_OFFSET);
    assign enables_wr = req.wr && tsf_hit(req.addr, `TSF_ENABLES_OFFSET);

    // ************************************************************
    // flag set and clear vectors
    // ************************************************************
    assign buffer_set = ev.buffer_moved || ev.serializer_release;

    always_comb begin
        set_vec.overwrite = ev.port_overwrite;
        set_vec.frame_start = ev.frame_start;
        set_vec.buffer_empty = buffer_set;
        set_vec.final_slot = buffer_set && ev.final_slot;
        set_vec.clock_fault = ev.clock_fault;
        set_vec.early_sync = ev.early_sync;
        set_vec.starved = ev.starved;
        // write one clears, zero ignored
        clr_vec.overwrite = status_wr &&
            req.wdata[`TSF_ST_OVERWRITE];
        clr_vec.frame_start = status_wr && req.wdata[`TSF_ST_FRAME_START];
        clr_vec.buffer_empty = status_wr && req.wdata[`TSF_ST_BUFFER_EMPTY];
        clr_vec.final_slot = status_wr && req.wdata[`TSF_ST_FINAL_SLOT];
        clr_vec.clock_fault = status_wr && req.wdata[`TSF_ST_CLOCK_FAULT];
        clr_vec.early_sync = status_wr && req.wdata[`TSF_ST_EARLY_SYNC];
        clr_vec.starved = status_wr && req.wdata[`TSF_ST_STARVED];
    end

    // ************************************************************
    // sticky flags
    // ************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < 7; gi = gi + 1) begin : g_flag
            tsf_flag_cell u_cell (
                .mclk(mclk),
                .rstn(rstn),
                .set_event(set_vec[gi]),
                .clear_write(clr_vec[gi]),
                .flag(flags[gi])
            );
        end
    endgenerate

    // ************************************************************
    // interrupt enables
    // ************************************************************
    always_comb begin
        next_enables = enables;
        if (enables_wr) begin
            next_enables = req.wdata[7:0] & `TSF_ENABLES_MASK;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            enables <= `TSF_ENABLES_RESET;
        end else begin
            enables <= next_enables;
        end
    end

    // level output; a set in the same cycle as its clear keeps it asserted
    assign tx_interrupt_request =
        (flags.frame_start && enables[`TSF_EN_FRAME_START]) ||
        (flags.buffer_empty && enables[`TSF_EN_BUFFER_EMPTY]) ||
        (flags.final_slot && enables[`TSF_EN_FINAL_SLOT]) ||
        (flags.overwrite && enables[`TSF_EN_OVERWRITE]) ||
        (flags.clock_fault && enables[`TSF_EN_CLOCK_FAULT]) ||
        (flags.early_sync && enables[`TSF_EN_EARLY_SYNC]) ||
        (flags.starved && enables[`TSF_EN_STARVED]);

    // ************************************************************
    // dma request: one-cycle pulse as the data ready flag is set
    // ************************************************************
    assign next_dma = buffer_set;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            tx_dma_request <= 1'b0;
        end else begin
            tx_dma_request <= next_dma;
        end
    end

    // ************************************************************
    // read path
    // ************************************************************
    assign error_sum = flags.starved || flags.early_sync ||
        flags.clock_fault || flags.overwrite;

    always_comb begin
        rdata_mux = 32'h00000000;
        if (tsf_hit(req.addr, `TSF_STATUS_OFFSET)) begin
            rdata_mux[`TSF_ST_ERROR_SUM] = error_sum;
            rdata_mux[`TSF_ST_OVERWRITE] = flags.overwrite;
            rdata_mux[`TSF_ST_FRAME_START] = flags.frame_start;
            rdata_mux[`TSF_ST_BUFFER_EMPTY] = flags.buffer_empty;
            rdata_mux[`TSF_ST_FINAL_SLOT] = flags.final_slot;
            rdata_mux[`TSF_ST_SLOT_PARITY] = tx_slot_counter_lsb;
            rdata_mux[`TSF_ST_CLOCK_FAULT] = flags.clock_fault;
            rdata_mux[`TSF_ST_EARLY_SYNC] = flags.early_sync;
            rdata_mux[`TSF_ST_STARVED] = flags.starved;
        end else if (tsf_hit(req.addr, `TSF_ENABLES_OFFSET)) begin
            rdata_mux[7:0] = enables;
        end
    end

    // read data valid only in the cycle after the strobe
    always_comb begin
        next_rdata = 32'h00000000;
        if (req.rd) begin
            next_rdata = rdata_mux;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 32'h00000000;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

endmodule

// file: rtl/tsf_defines.svh
// register offsets, field positions and reset values for the transmit status flags
`ifndef TSF_DEFINES_SVH
`define TSF_DEFINES_SVH

// ************************************************************
// offsets
// ************************************************************
`define TSF_STATUS_OFFSET 8'hC0
`define TSF_ENABLES_OFFSET 8'hBC
`define TSF_ADDR_W 8

// ************************************************************
// status register fields
// ************************************************************
`define TSF_ST_STARVED 0
`define TSF_ST_EARLY_SYNC 1
`define TSF_ST_CLOCK_FAULT 2
`define TSF_ST_SLOT_PARITY 3
`define TSF_ST_FINAL_SLOT 4
`define TSF_ST_BUFFER_EMPTY 5
`define TSF_ST_FRAME_START 6
`define TSF_ST_OVERWRITE 7
`define TSF_ST_ERROR_SUM 8

// ************************************************************
// interrupt enable register fields
// ************************************************************
`define TSF_EN_STARVED 0
`define TSF_EN_EARLY_SYNC 1
`define TSF_EN_CLOCK_FAULT 2
`define TSF_EN_OVERWRITE 3
`define TSF_EN_FINAL_SLOT 4
`define TSF_EN_BUFFER_EMPTY 5
`define TSF_EN_FRAME_START 7

// ************************************************************
// reset values and masks
// ************************************************************
`define TSF_FLAGS_RESET 7'h00
`define TSF_ENABLES_RESET 8'h00
`define TSF_ENABLES_MASK 8'hBF

`endif

// file: rtl/tsf_pkg.sv
// types shared by the transmit status flags block
package tsf_pkg;

    // hardware events, each a one-cycle pulse except final_slot, a level that qualifies the buffer move
    typedef struct packed {
        logic port_overwrite;
        logic frame_start;
        logic buffer_moved;
        logic serializer_release;
        logic final_slot;
        logic clock_fault;
        logic early_sync;
        logic starved;
    } tsf_events_t;

    // sticky flags in status-register order, bit 7 down to bit 0 minus bit 3
    typedef struct packed {
        logic overwrite;
        logic frame_start;
        logic buffer_empty;
        logic final_slot;
        logic clock_fault;
        logic early_sync;
        logic starved;
    } tsf_flags_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } tsf_bus_req_t;

    typedef enum logic [0:0] {
        TSF_RD_IDLE,
        TSF_RD_VALID
    } tsf_rd_state_t;

endpackage

// file: rtl/tsf_flag_cell.sv
// one sticky write-one-to-clear flag
`timescale 1ns/10ps
module tsf_flag_cell (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic set_event,
    input wire logic clear_write,
    output logic flag
);

    logic next_flag;

    // set beats clear so a colliding event is never lost
    always_comb begin
        next_flag = flag;
        if (clear_write) begin
            next_flag = 1'b0;
        end
        if (set_event) begin
            next_flag = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            flag <= 1'b0;
        end else begin
            flag <= next_flag;
        end
    end

endmodule

// file: test/tsf_flags_assertions.sv
// port assertions for the transmit status flags block
`timescale 1ns/10ps
`include "tsf_defines.svh"
module tsf_flags_assertions (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic port_overwrite,
    input wire logic frame_start,
    input wire logic buffer_moved,
    input wire logic serializer_release,
    input wire logic clock_fault,
    input wire logic early_sync,
    input wire logic starved,
    input wire logic tx_slot_counter_lsb,
    input wire logic tx_interrupt_request,
    input wire logic tx_dma_request
);
    logic ev_any;
    logic rd_st;
    assign ev_any = port_overwrite | frame_start | buffer_moved |
        serializer_release | clock_fault | early_sync | starved;
    assign rd_st = reg_rd && reg_addr == `TSF_STATUS_OFFSET;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    // ********
    // checks
    // ********
    dma_on_set_a: assert property (
        (buffer_moved || serializer_release) |=> tx_dma_request)
        else $error("dma request missing");
    dma_cause_a: assert property (
        tx_dma_request |-> $past(buffer_moved || serializer_release))
        else $error("dma request without cause");
    irq_cause_a: assert property (
        $rose(tx_interrupt_request) |-> $past(ev_any || reg_wr))
        else $error("interrupt without cause");
    irq_sticky_a: assert property (
        tx_interrupt_request && !reg_wr |=> tx_interrupt_request)
        else $error("interrupt dropped without write");
    rd_quiet_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside read slot");
    rsvd_zero_a: assert property (
        $past(reg_rd) |-> reg_rdata[31:9] == 23'h0)
        else $error("reserved bits not zero");
    err_sum_a: assert property ($past(rd_st) |-> reg_rdata[8] ==
        (reg_rdata[7] | reg_rdata[2] | reg_rdata[1] | reg_rdata[0]))
        else $error("error summary wrong");
    parity_a: assert property ($past(rd_st) |->
        reg_rdata[3] == $past(tx_slot_counter_lsb))
        else $error("slot parity wrong");
    en_rsvd_a: assert property (
        $past(reg_rd && reg_addr == `TSF_ENABLES_OFFSET) |->
        reg_rdata[6] == 1'b0 && reg_rdata[31:8] == 24'h0)
        else $error("enable reserved bits not zero");
endmodule

// file: test/tsf_host_model.sv
// host processor model driving the register port
`timescale 1ns/10ps
module tsf_host_model (
    input wire logic mclk,
    output logic [7:0] reg_addr,
    output logic [31:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [31:0] reg_rdata
);
    tsf_pkg::tsf_bus_req_t req = '{8'h00, 32'h0, 1'b0, 1'b0};
    assign {reg_addr, reg_wdata, reg_wr, reg_rd} = req;
    // ********
    // bus cycles
    // ********
    // ones clear, zeros leave alone reserved bits are caller's
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge mclk);
        req <= '{~a, ~d, 1'b0, 1'b0}; // idle bus shows no stale value
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        req <= '{a, ~req.wdata, 1'b0, 1'b1};
        @(posedge mclk);
        req <= '{~a, ~req.wdata, 1'b0, 1'b0};
        #1 d = reg_rdata;
    endtask
endmodule

// file: test/tsf_tb.sv
// testbench for the transmit status flags block
`timescale 1ns/10ps
`include "tsf_defines.svh"
module tb;
    typedef struct packed {
        logic [7:0] ev;
        logic [7:0] en;
        logic [31:0] st;
    } tsf_row_t;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic lsb = 1'b0;
    tsf_pkg::tsf_events_t ev = '0;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata;
    logic [31:0] got;
    logic reg_wr;
    logic reg_rd;
    logic irq;
    logic dma;
    int fail_count = 0;
    int checks_done = 0;
    int cycles = 0;
    // one event each (row 4 adds the last slot level to a buffer move), its own enable, expected status without parity
    tsf_row_t rows [8] = '{'{8'h80, 8'h08, 32'h180},
        '{8'h40, 8'h80, 32'h040}, '{8'h20, 8'h20, 32'h020},
        '{8'h10, 8'h20, 32'h020}, '{8'h28, 8'h10, 32'h030},
        '{8'h04, 8'h04, 32'h104}, '{8'h02, 8'h02, 32'h102},
        '{8'h01, 8'h01, 32'h101}};
    tsf_host_model host_u (.mclk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata);
    tsf_transmit_status_flags dut_u (.mclk, .rstn, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .port_overwrite(ev.port_overwrite),
        .frame_start(ev.frame_start), .buffer_moved(ev.buffer_moved),
        .serializer_release(ev.serializer_release),
        .final_slot(ev.final_slot), .clock_fault(ev.clock_fault),
        .early_sync(ev.early_sync), .starved(ev.starved),
        .tx_slot_counter_lsb(lsb), .tx_interrupt_request(irq),
        .tx_dma_request(dma));
    // ********
    // tasks
    // ********
    task automatic chk32(input string n, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk1(input string n, input logic e, g);
        chk32(n, {31'h0, e}, {31'h0, g});
    endtask
    task automatic pulse(input logic [7:0] e, input logic l);
        @(posedge mclk);
        ev <= e;
        lsb <= l;
        @(posedge mclk);
        ev <= '0;
        #1;
    endtask
    task automatic rdchk(string n, logic [7:0] a, logic [31:0] e);
        host_u.rd(a, got);
        chk32(n, e, got);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial forever #2.5 mclk = ~mclk;
    // a hang counts as a mismatch
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            final_report();
        end
    end
    initial begin
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        rdchk("status", `TSF_STATUS_OFFSET, 32'h0);
        rdchk("enables", `TSF_ENABLES_OFFSET, 32'h0);
        $display("reset test done");
        foreach (rows[i]) begin
            host_u.wr(`TSF_ENABLES_OFFSET, {24'h0, rows[i].en});
            pulse(rows[i].ev, i[0]);
            chk1("dma", rows[i].ev[5] | rows[i].ev[4], dma);
            chk1("irq", 1'b1, irq);
            rdchk("status", `TSF_STATUS_OFFSET,
                rows[i].st | {28'h0, i[0], 3'h0});
            host_u.wr(`TSF_STATUS_OFFSET, 32'hF7);
            #1 chk1("irq clear", 1'b0, irq);
            $display("row %0d done", i);
        end
        pulse(8'h01, 1'b0);
        host_u.wr(`TSF_STATUS_OFFSET, 32'h0);
        rdchk("keep", `TSF_STATUS_OFFSET, 32'h101);
        fork
            host_u.wr(`TSF_STATUS_OFFSET, 32'h1);
            pulse(8'h01, 1'b0);
        join
        chk1("set wins irq", 1'b1, irq);
        rdchk("set wins", `TSF_STATUS_OFFSET, 32'h101);
        host_u.wr(`TSF_STATUS_OFFSET, 32'hFFFFFE08);
        rdchk("read only", `TSF_STATUS_OFFSET, 32'h101);
        // last slot level alone must not set its flag or request dma
        pulse(8'h08, 1'b0);
        chk1("last alone dma", 1'b0, dma);
        rdchk("last alone", `TSF_STATUS_OFFSET, 32'h101);
        host_u.wr(`TSF_ENABLES_OFFSET, 32'hFFFFFFFF);
        rdchk("en mask", `TSF_ENABLES_OFFSET, 32'hBF);
        rdchk("unmapped", 8'h40, 32'h0);
        host_u.wr(`TSF_ENABLES_OFFSET, 32'h0);
        #1 chk1("masked", 1'b0, irq);
        $display("hand tests done");
        // mid-run reset with every flag and enable set
        pulse(8'hFF, 1'b1);
        host_u.wr(`TSF_ENABLES_OFFSET, 32'hBF);
        #1 chk1("pre reset irq", 1'b1, irq);
        @(posedge mclk);
        rstn <= 1'b0;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        #1 chk1("reset irq", 1'b0, irq);
        rdchk("reset flags", `TSF_STATUS_OFFSET, 32'h8);
        rdchk("reset enables", `TSF_ENABLES_OFFSET, 32'h0);
        $display("mid-run reset test done");
        final_report();
    end
endmodule
bind tsf_transmit_status_flags tsf_flags_assertions chk_u (.mclk, .rstn,
    .reg_addr, .reg_wr, .reg_rd, .reg_rdata, .port_overwrite, .frame_start,
    .buffer_moved, .serializer_release, .clock_fault, .early_sync, .starved,
    .tx_slot_counter_lsb, .tx_interrupt_request, .tx_dma_request);
